/* File: hw/mpi_channel_config.sv */
// Purpose: Serial command decoder and channel configuration registers.
// Assumes: SERIAL_DATA_CLOCK is the link clock; CS_N frames one byte per low period.
// Notes:   Bytes cross from the link domain by a toggle handshake.
`timescale 1ns/1ps
`include "mpi_cfg_regs.svh"

module mpi_channel_config
    import mpi_cfg_pkg::*;
#(
    parameter int NCH = 4
) (
    input  wire logic             SYS_CLK,          // System clock, 125 MHz.
    input  wire logic             RST,              // Reset, active high; synchronous to SYS_CLK, asynchronous in the link domain.
    input  wire logic             SERIAL_DATA_CLOCK, // Link data clock.
    input  wire logic             CS_N,             // Chip select, active low.
    input  wire logic             DIN,              // Serial data in.
    output logic                  DOUT,             // Serial data out.
    output logic                  DOUT_OE,          // High while driving DOUT.
    input  wire logic             FRAME_SYNC,       // Frame sync pin.
    input  wire logic             MU_LAW,           // Mu-law coding selected.
    input  wire logic             E1_MULTIPLEX_ENABLE, // E1 multiplex mode.
    input  wire logic [7:0]       RT_INPUTS,        // Debounced line inputs.
    input  wire logic [4:0]       IO_DIR_OUT,       // Pin is an output when 1.
    output logic [4:0]            IO_PIN_OUT,       // Latched pin values.
    output logic [4:0]            IO_PIN_OE,        // Pin output enables.
    output logic                  MUXED_FIRST_OUT,  // Muxed first-input output.
    output logic [NCH-1:0]        CHANNEL_ACTIVE_FLAG, // Channel active.
    output logic [NCH-1:0]        PCM_VALID,        // PCM samples valid.
    output logic [NCH*8-1:0]      TX_SLOT_SELECT,   // Per channel tx byte.
    output logic [NCH*8-1:0]      RX_SLOT_SELECT,   // Per channel rx byte.
    output logic                  TX_BOTH_HIGHWAYS, // Transmit on A and B.
    output logic                  TX_EDGE_SELECT,   // 1 = rising edge.
    output logic [2:0]            RX_BIT_CLOCK_OFFSET, // Receive clock slot.
    output logic [2:0]            TX_BIT_CLOCK_OFFSET, // Transmit clock slot.
    output logic                  IRQ_OUTPUT_TYPE,  // 1 = open drain.
    output logic                  CHOPPER_RATE_SELECT, // 1 = 292.57 kHz.
    output logic                  HIGHWAY_SIGNALING_ENABLE, // Signaling on.
    output logic                  MASTER_CLOCK_SOURCE, // 1 = PCM clock.
    output logic [3:0]            MASTER_FREQ_SELECT, // Master clock code.
    output logic                  MASTER_FREQ_RESERVED, // Code is reserved.
    output logic                  E1_ALLOWED,       // E1 multiplex allowed.
    output logic                  ROBBED_BIT_ACTIVE, // Robbed-bit on receive.
    output logic                  IDLE_OUTPUT_BEHAVIOUR, // Idle output mode.
    output logic                  LOW_POWER_ACTIVE, // Low power entered.
    output logic [NCH-1:0]        TX_ANALOG_GAIN,   // 6.02 dB tx gain.
    output logic [NCH-1:0]        RX_ANALOG_LOSS,   // 6.02 dB rx loss.
    output logic [NCH*5-1:0]      IMPEDANCE_SCALING_CODE, // Scaling codes.
    output logic [NCH-1:0]        FULL_LOOPBACK,    // Code 10000 loopback.
    output logic [NCH-1:0]        SCALING_CUTOFF,   // Code zero cutoff.
    output logic                  IRQ_PENDING       // Real-time interrupt.
);

    // Link domain: shift register and edge counter; only the counter is reset, held clear while CS_N is high.
    logic [7:0]  lk_shift_reg;
    logic [4:0]  lk_count_reg;
    logic        lk_toggle_reg;
    logic [7:0]  lk_byte_reg;
    logic        lk_hwrst_reg;
    logic [7:0]  lk_tx_reg;
    logic        cs_d_reg;
    logic [7:0]  rd_data_reg;

    // Each rising data clock edge shifts in one bit while selected.
    always_ff @(posedge SERIAL_DATA_CLOCK or posedge CS_N) begin
        if (CS_N) begin
            lk_count_reg <= 5'd0;
        end else begin
            lk_shift_reg <= {lk_shift_reg[6:0], DIN};
            if (lk_count_reg != 5'h1f) begin
                lk_count_reg <= lk_count_reg + 5'd1;
            end
        end
    end

    // At the end of the frame the byte is handed over by a toggle.
    always_ff @(posedge CS_N or posedge RST) begin
        if (RST) begin
            lk_hwrst_reg  <= 1'b0;
            lk_toggle_reg <= 1'b0;
            lk_byte_reg   <= 8'h00;
        end else if (lk_count_reg >= `FRAME_RESET_EDGES) begin
            lk_hwrst_reg  <= 1'b1;
            lk_toggle_reg <= ~lk_toggle_reg;
        end else if (lk_count_reg >= `FRAME_MIN_EDGES) begin
            lk_hwrst_reg  <= 1'b0;
            lk_byte_reg   <= lk_shift_reg; // Last eight edges only
            lk_toggle_reg <= ~lk_toggle_reg;
        end
    end

    // Read data shifts out on falling edges, MSB first; the first edge loads the
    // read byte, which only changes between frames and so is quiet here.
    always_ff @(negedge SERIAL_DATA_CLOCK or posedge CS_N) begin
        if (CS_N) begin
            cs_d_reg <= 1'b0;
        end else begin
            cs_d_reg  <= 1'b1;
            lk_tx_reg <= cs_d_reg ? {lk_tx_reg[6:0], 1'b0} : rd_data_reg;
        end
    end

    // System domain synchronisers.
    logic        tg_s1_reg, tg_s2_reg, tg_s3_reg;
    logic        fs_s1_reg, fs_s2_reg, fs_s3_reg;
    logic [7:0]  rt_s1_reg, rt_s2_reg;
    logic        cs_s1_reg, cs_s2_reg;

    always_ff @(posedge SYS_CLK) begin
        tg_s1_reg <= lk_toggle_reg;
        tg_s2_reg <= tg_s1_reg;
        tg_s3_reg <= tg_s2_reg;
        fs_s1_reg <= FRAME_SYNC;
        fs_s2_reg <= fs_s1_reg;
        fs_s3_reg <= fs_s2_reg;
        rt_s1_reg <= RT_INPUTS;
        rt_s2_reg <= rt_s1_reg;
        cs_s1_reg <= CS_N;
        cs_s2_reg <= cs_s1_reg;
    end

    wire byte_evt = tg_s2_reg ^ tg_s3_reg;
    wire fs_rise  = fs_s2_reg & ~fs_s3_reg;
    wire [7:0] rx_byte = lk_byte_reg;   // Stable for many cycles after toggle.
    wire hw_reset = RST | (byte_evt & lk_hwrst_reg);

    // Command state and registers.
    mpi_state_e  state_reg;
    logic [7:0]  cmd_reg;
    logic [NCH*8-1:0] txs_reg, rxs_reg;
    logic [7:0]  clk_slot_reg, config_reg, chan_en_reg, io_latch_reg;
    logic [NCH*8-1:0] gain_reg;
    logic [NCH-1:0]   active_reg;
    logic [2*NCH-1:0] fs_cnt_reg;
    logic        irq_reg;
    logic [7:0]  rt_last_reg;

    wire [NCH-1:0] en = chan_en_reg[NCH-1:0];
    wire any_en = |en;
    // Lowest enabled channel answers per-channel reads.
    wire [1:0] rd_ch = en[0] ? 2'd0 : en[1] ? 2'd1 : en[2] ? 2'd2 : 2'd3;
    wire is_write = (cmd_reg[0] == 1'b0);
    wire cmd_has_data = (rx_byte[7:4] == 4'h4 || rx_byte[7:4] == 4'h5)
        && rx_byte != `CMD_RD_RT_KEEP && rx_byte != `CMD_RD_RT_CLEAR;
    wire cmd_is_rt = (rx_byte == `CMD_RD_RT_KEEP) || (rx_byte == `CMD_RD_RT_CLEAR);

    // Read data selection for the byte following a read command.
    wire [7:0] rd_sel =
        (rx_byte == `CMD_RD_TX_SLOT)  ? txs_reg[rd_ch*8 +: 8] :
        (rx_byte == `CMD_RD_RX_SLOT)  ? rxs_reg[rd_ch*8 +: 8] :
        (rx_byte == `CMD_RD_CLK_SLOT) ? (any_en ? clk_slot_reg : 8'h00) :
        (rx_byte == `CMD_RD_CONFIG)   ? config_reg :
        (rx_byte == `CMD_RD_CHAN_EN)  ? {1'b0, chan_en_reg[6:0]} :
        (cmd_is_rt)                   ? rt_s2_reg :
        (rx_byte == `CMD_RD_GAIN)     ? {1'b0, gain_reg[rd_ch*8 + 0 +: 7]} :
        (rx_byte == `CMD_RD_IO_LATCH) ? {2'b00, io_latch_reg[5:0]} : 8'h00;

    // Command sequencer: command byte, then one data byte.
    always_ff @(posedge SYS_CLK) begin
        if (hw_reset) begin
            state_reg   <= ST_CMD;
            cmd_reg     <= 8'h00;
            rd_data_reg <= 8'h00;
        end else if (byte_evt) begin
            case (state_reg)
                ST_CMD: begin
                    cmd_reg <= rx_byte;
                    if (cmd_has_data && rx_byte[0] == 1'b0) begin
                        state_reg <= ST_WDATA;
                    end else if (cmd_has_data || cmd_is_rt) begin
                        state_reg   <= ST_RDATA;
                        rd_data_reg <= rd_sel;
                    end
                end
                default: begin
                    state_reg <= ST_CMD;
                end
            endcase
        end
    end

    wire wr_evt = byte_evt && state_reg == ST_WDATA && is_write;
    wire act_evt = byte_evt && state_reg == ST_CMD && rx_byte == `CMD_ACTIVATE;
    wire rt_clear = byte_evt && state_reg == ST_CMD && rx_byte == `CMD_RD_RT_CLEAR;

    // Per-channel registers and activation, one generate copy per channel.
    genvar ch;
    generate
        for (ch = 0; ch < NCH; ch++) begin : g_ch
            always_ff @(posedge SYS_CLK) begin
                if (hw_reset) begin
                    txs_reg[ch*8 +: 8]  <= 8'(ch); // Highway A, slot ch
                    rxs_reg[ch*8 +: 8]  <= 8'(ch);
                    gain_reg[ch*8 +: 8] <= `RST_GAIN;
                    active_reg[ch]      <= 1'b0;
                    fs_cnt_reg[ch*2 +: 2] <= 2'd0;
                end else begin
                    if (wr_evt && en[ch]) begin
                        if (cmd_reg == `CMD_WR_TX_SLOT) begin
                            txs_reg[ch*8 +: 8] <= rx_byte;
                        end
                        if (cmd_reg == `CMD_WR_RX_SLOT) begin
                            rxs_reg[ch*8 +: 8] <= rx_byte;
                        end
                        if (cmd_reg == `CMD_WR_GAIN) begin
                            gain_reg[ch*8 +: 8] <= {1'b0, rx_byte[6:0]};
                        end
                    end
                    if (act_evt && en[ch]) begin
                        active_reg[ch]        <= 1'b1;
                        fs_cnt_reg[ch*2 +: 2] <= 2'd0;
                    end else if (fs_rise && active_reg[ch]
                                 && fs_cnt_reg[ch*2 +: 2] != `ACTIVE_FS_WAIT) begin
                        fs_cnt_reg[ch*2 +: 2] <= fs_cnt_reg[ch*2 +: 2] + 2'd1;
                    end
                end
            end
        end
    endgenerate

    // Global registers; clock slot access requires an enabled channel.
    always_ff @(posedge SYS_CLK) begin
        if (hw_reset) begin
            clk_slot_reg <= `RST_CLK_SLOT;
            config_reg   <= `RST_CONFIG;
            chan_en_reg  <= `RST_CHAN_EN;
            io_latch_reg <= `RST_IO_LATCH;
        end else if (wr_evt) begin
            if (cmd_reg == `CMD_WR_CLK_SLOT && any_en) begin
                clk_slot_reg <= rx_byte;
            end
            if (cmd_reg == `CMD_WR_CONFIG) begin
                config_reg <= rx_byte; // Independent of enables
            end
            if (cmd_reg == `CMD_WR_CHAN_EN) begin
                chan_en_reg <= {1'b0, rx_byte[6:0]};
            end
            if (cmd_reg == `CMD_WR_IO_LATCH) begin
                io_latch_reg <= {2'b00, rx_byte[5:0]};
            end
        end
    end

    // Interrupt: input change sets it; set wins over a 4Fh clear.
    always_ff @(posedge SYS_CLK) begin
        if (hw_reset) begin
            irq_reg     <= 1'b0;
            rt_last_reg <= 8'h00;
        end else begin
            rt_last_reg <= rt_s2_reg;
            if (rt_s2_reg != rt_last_reg) begin
                irq_reg <= 1'b1;
            end else if (rt_clear) begin
                irq_reg <= 1'b0; // 4Dh leaves it
            end
        end
    end

    // Decoded views of the register contents.
    logic [NCH-1:0] lb_w, cut_w, tga_w, rxl_w, pv_w;
    logic [NCH*5-1:0] isc_w;
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            isc_w[i*5 +: 5] = gain_reg[i*8 +: 5];
            tga_w[i] = gain_reg[i*8 + `POS_AX];
            rxl_w[i] = gain_reg[i*8 + `POS_AR];
            lb_w[i]  = (gain_reg[i*8 +: 5] == `IMPEDANCE_SCALING_CODE_LOOPBACK);
            cut_w[i] = (gain_reg[i*8 +: 5] == 5'h00);
            pv_w[i]  = active_reg[i] && fs_cnt_reg[i*2 +: 2] == `ACTIVE_FS_WAIT;
        end
    end

    wire freq_res = (config_reg[3:0] == 4'h3) || (config_reg[3:2] == 2'b11);
    wire e1_ok = config_reg[`POS_MASTER_CLOCK_SOURCE];

    // All outputs are registered.
    always_ff @(posedge SYS_CLK) begin
        if (RST) begin
            DOUT_OE <= 1'b0;
        end else begin
            DOUT_OE <= (state_reg == ST_RDATA) && !cs_s2_reg;
        end
        DOUT                     <= lk_tx_reg[7];
        CHANNEL_ACTIVE_FLAG      <= active_reg;
        PCM_VALID                <= pv_w;
        TX_SLOT_SELECT           <= txs_reg;
        RX_SLOT_SELECT           <= rxs_reg;
        TX_BOTH_HIGHWAYS         <= clk_slot_reg[`POS_TAB];
        TX_EDGE_SELECT           <= clk_slot_reg[`POS_XE];
        RX_BIT_CLOCK_OFFSET      <= clk_slot_reg[5:3];
        TX_BIT_CLOCK_OFFSET      <= clk_slot_reg[2:0];
        IRQ_OUTPUT_TYPE          <= config_reg[`POS_IRQ_OUTPUT_TYPE];
        CHOPPER_RATE_SELECT      <= config_reg[`POS_CHP];
        HIGHWAY_SIGNALING_ENABLE <= config_reg[`POS_HIGHWAY_SIGNALING_ENABLE];
        MASTER_CLOCK_SOURCE      <= config_reg[`POS_MASTER_CLOCK_SOURCE];
        MASTER_FREQ_SELECT       <= config_reg[3:0];
        MASTER_FREQ_RESERVED     <= freq_res;
        E1_ALLOWED               <= e1_ok & E1_MULTIPLEX_ENABLE;
        ROBBED_BIT_ACTIVE        <= chan_en_reg[`POS_RBE] & MU_LAW;
        IDLE_OUTPUT_BEHAVIOUR    <= chan_en_reg[`POS_IDLE_OUTPUT_BEHAVIOUR];
        LOW_POWER_ACTIVE         <= chan_en_reg[`POS_LPM] & ~(|active_reg);
        TX_ANALOG_GAIN           <= tga_w;
        RX_ANALOG_LOSS           <= rxl_w;
        IMPEDANCE_SCALING_CODE   <= isc_w;
        FULL_LOOPBACK            <= lb_w;
        SCALING_CUTOFF           <= cut_w;
        IO_PIN_OUT               <= io_latch_reg[4:0];
        IO_PIN_OE                <= IO_DIR_OUT;
        MUXED_FIRST_OUT          <= io_latch_reg[`POS_MUXED_FIRST_OUTPUT_BIT] & E1_MULTIPLEX_ENABLE
                                    & e1_ok;
        IRQ_PENDING              <= irq_reg;
    end

    // The no-operation code falls through every decode; only cmd_reg is loaded with it.
    wire nop_seen = (rx_byte == `CMD_NOP);

endmodule : mpi_channel_config

/* File: inc/mpi_cfg_pkg.sv */
// Purpose: Types shared by the command decoder.
// Assumes: Nothing.
// Notes:   Constants live in the _regs header.
package mpi_cfg_pkg;
    typedef enum logic [1:0] {
        ST_CMD,
        ST_WDATA,
        ST_RDATA
    } mpi_state_e;
endpackage : mpi_cfg_pkg

/* File: inc/mpi_cfg_regs.svh */
// Purpose: Command codes, reset values and field positions of the channel
//          configuration command decoder.
// Assumes: Included by its bare name.
// Notes:   Definitions only.
`ifndef MPI_CFG_REGS_SVH
`define MPI_CFG_REGS_SVH

`define CMD_NOP           8'h06
`define CMD_ACTIVATE      8'h0e
`define CMD_WR_TX_SLOT    8'h40
`define CMD_RD_TX_SLOT    8'h41
`define CMD_WR_RX_SLOT    8'h42
`define CMD_RD_RX_SLOT    8'h43
`define CMD_WR_CLK_SLOT   8'h44
`define CMD_RD_CLK_SLOT   8'h45
`define CMD_WR_CONFIG     8'h46
`define CMD_RD_CONFIG     8'h47
`define CMD_WR_CHAN_EN    8'h4a
`define CMD_RD_CHAN_EN    8'h4b
`define CMD_RD_RT_KEEP    8'h4d
`define CMD_RD_RT_CLEAR   8'h4f
`define CMD_WR_GAIN       8'h50
`define CMD_RD_GAIN       8'h51
`define CMD_WR_IO_LATCH   8'h52
`define CMD_RD_IO_LATCH   8'h53

`define RST_CLK_SLOT      8'h00
`define RST_CONFIG        8'h9a
`define RST_CHAN_EN       8'h0f
`define RST_GAIN          8'h00
`define RST_IO_LATCH      8'h00

`define POS_HIGHWAY       7
`define POS_TAB           7
`define POS_XE            6
`define POS_IRQ_OUTPUT_TYPE          7
`define POS_CHP           6
`define POS_HIGHWAY_SIGNALING_ENABLE         5
`define POS_MASTER_CLOCK_SOURCE         4
`define POS_RBE           6
`define POS_IDLE_OUTPUT_BEHAVIOUR         5
`define POS_LPM           4
`define POS_AX            6
`define POS_AR            5
`define POS_MUXED_FIRST_OUTPUT_BIT          5
`define IMPEDANCE_SCALING_CODE_LOOPBACK     5'h10

`define FRAME_MIN_EDGES   5'd8
`define FRAME_RESET_EDGES 5'd16
`define ACTIVE_FS_WAIT    2'd2

`endif

/* File: testbench/mpi_channel_config_sva.sv */
// Purpose: Port checker for the channel configuration decoder.
// Assumes: Bound to every instance of the decoder.
// Notes:   Watches the system clock domain only.
`timescale 1ns/1ps
module mpi_channel_config_sva #(
    parameter int NCH = 4
) (
    input wire logic             SYS_CLK,              // System clock.
    input wire logic             RST,                  // Reset, active high.
    input wire logic             MU_LAW,               // Coding select.
    input wire logic             E1_MULTIPLEX_ENABLE,  // Multiplex mode.
    input wire logic [4:0]       IO_DIR_OUT,           // Pin directions.
    input wire logic [4:0]       IO_PIN_OE,            // Pin enables.
    input wire logic             MUXED_FIRST_OUT,      // Muxed output bit.
    input wire logic [NCH-1:0]   CHANNEL_ACTIVE_FLAG,  // Channel active.
    input wire logic [NCH-1:0]   PCM_VALID,            // PCM valid.
    input wire logic [NCH*8-1:0] TX_SLOT_SELECT,       // Transmit slots.
    input wire logic [NCH*8-1:0] RX_SLOT_SELECT,       // Receive slots.
    input wire logic             MASTER_CLOCK_SOURCE,  // Clock source.
    input wire logic [3:0]       MASTER_FREQ_SELECT,   // Frequency code.
    input wire logic             MASTER_FREQ_RESERVED, // Reserved code.
    input wire logic             E1_ALLOWED,           // Multiplex allowed.
    input wire logic             ROBBED_BIT_ACTIVE,    // Robbed-bit on.
    input wire logic             LOW_POWER_ACTIVE,     // Low power on.
    input wire logic [NCH*5-1:0] IMPEDANCE_SCALING_CODE, // Scaling codes.
    input wire logic [NCH-1:0]   FULL_LOOPBACK,        // Loopback.
    input wire logic [NCH-1:0]   SCALING_CUTOFF        // Cutoff.
);
    logic [NCH-1:0] loop_exp;
    logic [NCH-1:0] cut_exp;

    // Expected decode of each channel's scaling code.
    always_comb begin
        for (int i = 0; i < NCH; i++) begin
            loop_exp[i] = IMPEDANCE_SCALING_CODE[i*5+:5] == 5'h10;
            cut_exp[i]  = IMPEDANCE_SCALING_CODE[i*5+:5] == 5'h00;
        end
    end

    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (RST);

    property p_slot_reset;
        $fell(RST) |=> TX_SLOT_SELECT == 32'h03020100 && RX_SLOT_SELECT == 32'h03020100
            && MASTER_FREQ_SELECT == 4'ha;
    endproperty
    a_slot_reset: assert property (p_slot_reset) else $error("reset values wrong");
    property p_rsv;
        MASTER_FREQ_RESERVED == (MASTER_FREQ_SELECT == 4'h3 || MASTER_FREQ_SELECT[3:2] == 2'h3);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved code flag wrong");
    property p_loop;
        FULL_LOOPBACK == loop_exp && SCALING_CUTOFF == cut_exp;
    endproperty
    a_loop: assert property (p_loop) else $error("scaling decode wrong");
    property p_e1;
        E1_ALLOWED |-> MASTER_CLOCK_SOURCE;
    endproperty
    a_e1: assert property (p_e1) else $error("multiplex allowed on clock pin");
    property p_lpm;
        LOW_POWER_ACTIVE |-> CHANNEL_ACTIVE_FLAG == '0;
    endproperty
    a_lpm: assert property (p_lpm) else $error("low power while active");
    property p_pcm;
        (PCM_VALID & ~CHANNEL_ACTIVE_FLAG) == '0;
    endproperty
    a_pcm: assert property (p_pcm) else $error("pcm valid on idle channel");
    property p_rbe;
        (!MU_LAW) [*6] |-> !ROBBED_BIT_ACTIVE;
    endproperty
    a_rbe: assert property (p_rbe) else $error("robbed bit without mu-law");
    property p_mux;
        (!E1_MULTIPLEX_ENABLE) [*6] |-> !MUXED_FIRST_OUT;
    endproperty
    a_mux: assert property (p_mux) else $error("muxed bit without multiplex");
    property p_oe;
        $stable(IO_DIR_OUT) [*6] |-> IO_PIN_OE == IO_DIR_OUT;
    endproperty
    a_oe: assert property (p_oe) else $error("pin enable differs from direction");
endmodule : mpi_channel_config_sva

bind mpi_channel_config mpi_channel_config_sva #(.NCH(NCH)) mpi_channel_config_sva_i (.*);

/* File: testbench/mpi_host_model.sv */
// Purpose: Host processor driving the serial command interface.
// Assumes: Data clock rests high outside frames, 64 ns period inside.
// Notes:   Read bits are taken on the rising data clock edge.
`timescale 1ns/1ps
module mpi_host_model (
    output logic      SERIAL_DATA_CLOCK, // Data clock.
    output logic      CS_N,              // Chip select.
    output logic      DIN,               // Serial data to device.
    input  wire logic DOUT,              // Serial data from device.
    input  wire logic DOUT_OE            // Device drives read data.
);
    // Idle state before the first frame.
    initial begin
        SERIAL_DATA_CLOCK = 1'b1;
        CS_N = 1'b1;
        DIN = 1'b0;
    end

    // One frame of n rising edges, MSB first; the last eight bits of data count.
    task automatic frame(input int n, input logic [15:0] data, output logic [7:0] rd);
        CS_N = 1'b0;
        #43;
        for (int i = n - 1; i >= 0; i--) begin
            DIN = data[i];
            SERIAL_DATA_CLOCK = 1'b0;
            #32;
            SERIAL_DATA_CLOCK = 1'b1;
            rd = {rd[6:0], DOUT_OE ? DOUT : 1'bx};
            #32;
        end
        CS_N = 1'b1;
        DIN = ~DIN;
        #200;
    endtask : frame
endmodule : mpi_host_model

/* File: testbench/quad_codec_mpi_channel_config_bench.sv */
// Purpose: Self-checking bench for the channel configuration decoder.
// Assumes: Host model on the serial side, random data from a fixed seed.
// Notes:   Expected values come from bench constants, stimulus and the upd function.
`timescale 1ns/1ps
module quad_codec_mpi_channel_config_bench;
    logic        SYS_CLK, RST, FRAME_SYNC, MU_LAW, E1_MULTIPLEX_ENABLE, SERIAL_DATA_CLOCK;
    logic        CS_N, DIN, DOUT, DOUT_OE, MUXED_FIRST_OUT, TX_BOTH_HIGHWAYS, TX_EDGE_SELECT;
    logic        IRQ_OUTPUT_TYPE, CHOPPER_RATE_SELECT, HIGHWAY_SIGNALING_ENABLE, E1_ALLOWED;
    logic        MASTER_CLOCK_SOURCE, MASTER_FREQ_RESERVED, ROBBED_BIT_ACTIVE, IRQ_PENDING;
    logic        IDLE_OUTPUT_BEHAVIOUR, LOW_POWER_ACTIVE;
    logic [7:0]  RT_INPUTS, r, v;
    logic [4:0]  IO_DIR_OUT, IO_PIN_OUT, IO_PIN_OE;
    logic [3:0]  CHANNEL_ACTIVE_FLAG, PCM_VALID, TX_ANALOG_GAIN, RX_ANALOG_LOSS;
    logic [3:0]  FULL_LOOPBACK, SCALING_CUTOFF, MASTER_FREQ_SELECT;
    logic [31:0] TX_SLOT_SELECT, RX_SLOT_SELECT, tx;
    logic [19:0] IMPEDANCE_SCALING_CODE;
    logic [2:0]  RX_BIT_CLOCK_OFFSET, TX_BIT_CLOCK_OFFSET;
    int          n_mismatch = 0;
    int          check_count = 0;
    int          seed = 33104;

    mpi_channel_config #(.NCH(4)) mpi_channel_config_i (.*);
    mpi_host_model mpi_host_model_i (.*);

    // System clock, 8 ns period.
    always #4 SYS_CLK = ~SYS_CLK;

    task automatic tick(input int n);
        repeat (n) @(posedge SYS_CLK);
        #1;
    endtask : tick

    task automatic chk(input logic [63:0] got, input logic [63:0] exp, input string what);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s", $time, what);
        end
    endtask : chk

    task automatic wr(input logic [7:0] cmd, input logic [7:0] d);
        mpi_host_model_i.frame(8, {8'h00, cmd}, r);
        mpi_host_model_i.frame(8, {8'h00, d}, r);
        tick(1);
    endtask : wr

    task automatic rd(input logic [7:0] cmd);
        mpi_host_model_i.frame(8, {8'h00, cmd}, r);
        mpi_host_model_i.frame(8, 16'h0000, r);
    endtask : rd

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : give_verdict

    // Per-channel byte update, limited to enabled channels.
    function automatic logic [31:0] upd(input logic [31:0] old, input logic [3:0] en,
                                        input logic [7:0] d);
        for (int i = 0; i < 4; i++) begin
            if (en[i]) old[i*8+:8] = d;
        end
        return old;
    endfunction : upd

    // Main sequence.
    initial begin
        {SYS_CLK, FRAME_SYNC, MU_LAW, E1_MULTIPLEX_ENABLE} = 4'h0;
        RST = 1'b1;
        RT_INPUTS = 8'h00;
        IO_DIR_OUT = 5'h00;
        tick(3);
        RST = 1'b0;
        tick(4);
        tx = 32'h03020100;
        chk({TX_SLOT_SELECT, RX_SLOT_SELECT}, {tx, tx}, "slot reset");
        chk({IRQ_OUTPUT_TYPE, CHOPPER_RATE_SELECT, HIGHWAY_SIGNALING_ENABLE, MASTER_CLOCK_SOURCE,
             MASTER_FREQ_SELECT}, 8'h9a, "config reset");
        chk({TX_BOTH_HIGHWAYS, TX_EDGE_SELECT, RX_BIT_CLOCK_OFFSET, TX_BIT_CLOCK_OFFSET,
             ROBBED_BIT_ACTIVE, LOW_POWER_ACTIVE, TX_ANALOG_GAIN, IMPEDANCE_SCALING_CODE,
             IO_PIN_OUT, CHANNEL_ACTIVE_FLAG}, 64'h0, "zero reset");
        for (int k = 0; k < 3; k++) begin
            v = k == 0 ? 8'hff : 8'($random(seed));
            wr(8'h40, v);
            tx = {4{v}};
            rd(8'h41);
            chk({TX_SLOT_SELECT, r}, {tx, v}, "tx slot");
            wr(8'h42, ~v);
            rd(8'h43);
            chk({RX_SLOT_SELECT, r}, {{4{~v}}, ~v}, "rx slot");
        end
        mpi_host_model_i.frame(8, 16'h0006, r);
        chk(TX_SLOT_SELECT, tx, "no operation");
        wr(8'h4a, 8'h02);
        v = 8'($random(seed));
        wr(8'h40, v);
        rd(8'h41);
        chk({TX_SLOT_SELECT, r}, {upd(tx, 4'h2, v), v}, "enable gate");
        wr(8'h4a, 8'h00);
        wr(8'h44, 8'hff);
        rd(8'h45);
        chk({TX_BOTH_HIGHWAYS, TX_EDGE_SELECT, RX_BIT_CLOCK_OFFSET, TX_BIT_CLOCK_OFFSET, r},
            16'h0, "clock slot refused");
        wr(8'h4a, 8'h0f);
        for (int k = 0; k < 2; k++) begin
            v = k ? 8'($random(seed)) | 8'hc0 : 8'($random(seed)) & 8'h3f;
            wr(8'h44, v);
            rd(8'h45);
            chk({TX_BOTH_HIGHWAYS, TX_EDGE_SELECT, RX_BIT_CLOCK_OFFSET, TX_BIT_CLOCK_OFFSET, r},
                {v, v}, "clock slot");
        end
        for (int k = 0; k < 16; k++) begin
            v = 8'($random(seed));
            v[3:0] = 4'(k);
            E1_MULTIPLEX_ENABLE = v[7];
            wr(8'h46, v);
            rd(8'h47);
            chk({IRQ_OUTPUT_TYPE, CHOPPER_RATE_SELECT, HIGHWAY_SIGNALING_ENABLE, MASTER_CLOCK_SOURCE,
                 MASTER_FREQ_SELECT, r}, {v, v}, "config");
            chk({MASTER_FREQ_RESERVED, E1_ALLOWED}, {k == 3 || k >= 12, v[4] & v[7]}, "clock");
        end
        wr(8'h46, 8'h9a);
        wr(8'h4a, 8'h75);
        rd(8'h4b);
        chk({r[6:0], ROBBED_BIT_ACTIVE, IDLE_OUTPUT_BEHAVIOUR, LOW_POWER_ACTIVE},
            {7'h75, 3'h3}, "mode");
        MU_LAW = 1'b1;
        tick(8);
        chk(ROBBED_BIT_ACTIVE, 1'b1, "robbed bit");
        mpi_host_model_i.frame(8, 16'h000e, r);
        chk({CHANNEL_ACTIVE_FLAG, LOW_POWER_ACTIVE}, 5'h0a, "activate");
        for (int k = 0; k < 2; k++) begin
            chk(PCM_VALID, 4'h0, "pcm held off");
            FRAME_SYNC = 1'b1;
            tick(2);
            FRAME_SYNC = 1'b0;
            tick(20);
        end
        chk(PCM_VALID, 4'h5, "pcm valid");
        wr(8'h4a, 8'h0f);
        for (int k = 0; k < 3; k++) begin
            v = 8'($random(seed)) & 8'h7f;
            if (k < 2) v[4:0] = k ? 5'h10 : 5'h00;
            wr(8'h50, v);
            rd(8'h51);
            chk({TX_ANALOG_GAIN, RX_ANALOG_LOSS, IMPEDANCE_SCALING_CODE, r[6:0]},
                {{4{v[6]}}, {4{v[5]}}, {4{v[4:0]}}, v[6:0]}, "gain");
            chk({FULL_LOOPBACK, SCALING_CUTOFF}, {{4{v[4:0] == 5'h10}}, {4{v[4:0] == 5'h00}}},
                "scaling");
        end
        for (int k = 0; k < 2; k++) begin
            v = 8'($random(seed)) & 8'h3f | 8'h20;
            IO_DIR_OUT = 5'($random(seed));
            E1_MULTIPLEX_ENABLE = k[0];
            wr(8'h52, v);
            rd(8'h53);
            chk({IO_PIN_OE, IO_PIN_OUT & IO_DIR_OUT, r[5:0]},
                {IO_DIR_OUT, v[4:0] & IO_DIR_OUT, v[5:0]}, "io latch");
            chk(MUXED_FIRST_OUT, k[0], "muxed bit");
        end
        wr(8'h4a, 8'h00);
        RT_INPUTS = 8'($random(seed)) | 8'h01;
        for (int k = 0; k < 50 && IRQ_PENDING !== 1'b1; k++) tick(1);
        chk(IRQ_PENDING, 1'b1, "irq raised");
        if (IRQ_PENDING !== 1'b1) give_verdict();
        rd(8'h4d);
        chk({r, IRQ_PENDING}, {RT_INPUTS, 1'b1}, "read keep");
        rd(8'h4f);
        tick(8);
        chk({r, IRQ_PENDING}, {RT_INPUTS, 1'b0}, "read clear");
        wr(8'h4a, 8'h0f);
        v = 8'($random(seed));
        mpi_host_model_i.frame(12, 16'h0a40, r);
        mpi_host_model_i.frame(5, 16'h001f, r);
        mpi_host_model_i.frame(8, {8'h00, v}, r);
        chk(TX_SLOT_SELECT, {4{v}}, "frame edges");
        mpi_host_model_i.frame(16, 16'hffff, r);
        chk({TX_SLOT_SELECT, MASTER_FREQ_SELECT}, {32'h03020100, 4'ha}, "frame reset");
        give_verdict();
    end
endmodule : quad_codec_mpi_channel_config_bench
